//--- src/lcdsd_top.sv
// Top of the LCD segment driver: display memory, drive switch register,
// common and segment output generation.
// Assumes low_osc_in is an asynchronous slow clock far below clk_sys and
// that bias voltages are produced outside from the digital levels.
`timescale 1ns/100ps

// Summary of operation
// (R1) Four commons, 48 segments, 192 segments
// (R2) 1/4 duty default, 1/3 duty option
// (R3) Frame is oscillator over 1024 or 768
// (R4) Software: set static bit, equal commons
// (R5) Static drive keeps fourth common active
// (R6) Software lights all segments when trimming
// (R7) Memory in page 0 or page 2
// (R8) Segment to memory bit map fixed
// (R9) DC segments output common zero bit
// (R10) DC selection by even/odd segment pairs
// (R11) DC pin push-pull or P open drain
// (R12) Drive bit: one static, reads, resets zero
// (R13) Page 0 reads data, page 2 undefined
// (R14) One lights segment; memory undefined at reset
// (R15) Page 2: software keeps shadow copy
// (R16) Forty-eight words of four bits
// (R17) Dynamic drive scans commons every frame
module lcdsd_top
  import lcdsd_pkg::*;
#(
  parameter logic           PAGE2      = 1'b0,
  parameter logic           DUTY_THIRD = 1'b0,
  parameter logic [NPAIR-1:0] DC_PAIRS = '0,
  parameter logic [NSEG-1:0] OPEN_DRAIN = '0,
  parameter lcdsd_map_all_t SEG_MAP    = lcdsd_default_map()
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  // Register port
  input  wire lcdsd_bus_t      bus,
  output logic [3:0]           rd_data,
  // Low oscillator pin
  input  wire logic            low_osc_in,
  // Clock timer mask bits
  output logic                 tick32_int_mask,
  output logic                 tick8_int_mask,
  output logic                 tick2_int_mask,
  // Panel drive
  output logic [NCOM-1:0]      common_outputs,
  output logic                 common_phase,
  output logic [NSEG-1:0]      segment_outputs,
  output logic [NSEG-1:0]      segment_oe
);

  // ==========================================================
  // Address decode helpers
  function automatic logic [11:0] mem_base();
    return PAGE2 ? MEM_BASE_P2 : MEM_BASE_P0;
  endfunction : mem_base

  function automatic logic in_mem(input logic [11:0] a);
    return (a >= mem_base()) &&
           (a < mem_base() + 12'(NWORD)); // (R7)
  endfunction : in_mem

  function automatic logic [5:0] mem_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - mem_base();
    return d[5:0];
  endfunction : mem_idx

  // ==========================================================
  // Oscillator synchroniser and edge detect
  logic       osc_s1_q, osc_s2_q, osc_s3_q;
  logic       osc_tick;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= low_osc_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q & ~osc_s3_q;

  // ==========================================================
  // Display memory, no reset
  logic [3:0] mem_q [NWORD];
  logic [3:0] mem_d [NWORD];

  always_comb begin
    for (int w = 0; w < NWORD; w++) begin
      mem_d[w] = mem_q[w];
    end
    if (bus.wr && in_mem(bus.addr)) begin
      mem_d[mem_idx(bus.addr)] = bus.wdata; // (R16)
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int w = 0; w < NWORD; w++) begin
      mem_q[w] <= mem_d[w]; // (R14)
    end
  end

  // ==========================================================
  // Drive switch and mask register
  lcdsd_mode_t mode_q, mode_d;
  logic [2:0]  mask_q, mask_d;

  always_comb begin
    mode_d = mode_q;
    mask_d = mask_q;
    if (bus.wr && bus.addr == REG_DRIVE) begin
      mode_d = bus.wdata[BIT_STATIC] ? LCDSD_STAT : LCDSD_DYN; // (R12)
      mask_d = bus.wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_q <= DRIVE_RST[BIT_STATIC] ? LCDSD_STAT : LCDSD_DYN; // (R12)
      mask_q <= DRIVE_RST[2:0];
    end else begin
      mode_q <= mode_d;
      mask_q <= mask_d;
    end
  end

  assign tick32_int_mask = mask_q[0];
  assign tick8_int_mask  = mask_q[1];
  assign tick2_int_mask  = mask_q[2];

  // ==========================================================
  // Read data, one cycle after the strobe
  logic [3:0] rd_q, rd_d;

  always_comb begin
    rd_d = 4'h0;
    if (bus.rd) begin
      if (bus.addr == REG_DRIVE) begin
        rd_d = {mode_q == LCDSD_STAT, mask_q}; // (R12)
      end else if (in_mem(bus.addr)) begin
        rd_d = PAGE2 ? RD_UNDEF : mem_q[mem_idx(bus.addr)]; // (R13)
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_q <= 4'h0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;

  // ==========================================================
  // Frame sequencer
  lcdsd_timing_t tm;
  logic          is_static;

  assign is_static = (mode_q == LCDSD_STAT);

  lcdsd_frame_gen u_frame (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .osc_tick    (osc_tick), // (R3)
    .duty_third  (DUTY_THIRD), // (R2)
    .static_mode (is_static),
    .timing      (tm)
  );

  // ==========================================================
  // Panel outputs
  logic [NCOM-1:0] com_q, com_d;
  logic            ph_q, ph_d;
  logic [NSEG-1:0] seg_q, seg_d;
  logic [NSEG-1:0] oe_q, oe_d;

  always_comb begin
    lcdsd_map_t m;
    lcdsd_map_t m0;
    logic       lit;
    logic       dc;
    m    = '0;
    m0   = '0;
    lit  = 1'b0;
    dc   = 1'b0;
    ph_d = tm.phase;
    com_d = '0;
    if (is_static) begin
      com_d = {NCOM{tm.phase}}; // (R5)
    end else begin
      com_d[tm.slot] = ~tm.phase; // (R17)
    end
    for (int s = 0; s < NSEG; s++) begin
      m   = SEG_MAP[s][tm.slot]; // (R8)
      m0  = SEG_MAP[s][0];
      dc  = DC_PAIRS[s / 2]; // (R10)
      lit = is_static ? mem_q[m0.word][m0.bitn]
                      : mem_q[m.word][m.bitn]; // (R14)
      if (dc) begin
        seg_d[s] = mem_q[m0.word][m0.bitn]; // (R9)
        oe_d[s]  = OPEN_DRAIN[s] ? seg_d[s] : 1'b1; // (R11)
      end else begin
        seg_d[s] = lit ^ tm.phase; // (R1)
        oe_d[s]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      com_q <= '0;
      ph_q  <= 1'b0;
      seg_q <= '0;
      oe_q  <= '0;
    end else begin
      com_q <= com_d;
      ph_q  <= ph_d;
      seg_q <= seg_d;
      oe_q  <= oe_d;
    end
  end

  assign common_outputs  = com_q;
  assign common_phase    = ph_q;
  assign segment_outputs = seg_q;
  assign segment_oe      = oe_q;

endmodule : lcdsd_top

//--- src/lcdsd_pkg.sv
// Constants, types and default segment map of the LCD segment driver.
// Assumes a 12-bit CPU address space and 4-bit data words.
package lcdsd_pkg;

  // ==========================================================
  // Geometry
  localparam int NSEG  = 48;
  localparam int NCOM  = 4;
  localparam int NWORD = 48;
  localparam int NPAIR = NSEG / 2;

  // ==========================================================
  // Address map
  localparam logic [11:0] MEM_BASE_P0 = 12'h040;
  localparam logic [11:0] MEM_BASE_P2 = 12'h240;
  localparam logic [11:0] REG_DRIVE   = 12'h2E8;
  localparam int          BIT_STATIC  = 3;
  localparam logic [3:0]  DRIVE_RST   = 4'h0;
  localparam logic [3:0]  RD_UNDEF    = 4'h0;

  // ==========================================================
  // Frame timing, in low oscillator periods
  localparam int FRAME_DIV_QUARTER = 1024;
  localparam int FRAME_DIV_THIRD   = 768;
  localparam int SLOT_TICKS        = FRAME_DIV_QUARTER / NCOM;
  localparam int CNT_W             = $clog2(FRAME_DIV_QUARTER);
  localparam int SLOT_LSB          = $clog2(SLOT_TICKS);

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LCDSD_DYN  = 2'b01,
    LCDSD_STAT = 2'b10
  } lcdsd_mode_t;

  typedef struct packed {
    logic [5:0] word;
    logic [1:0] bitn;
  } lcdsd_map_t;

  typedef lcdsd_map_t [NCOM-1:0]     lcdsd_segmap_t;
  typedef lcdsd_segmap_t [NSEG-1:0]  lcdsd_map_all_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [3:0]  wdata;
    logic        wr;
    logic        rd;
  } lcdsd_bus_t;

  typedef struct packed {
    logic [1:0] slot;
    logic       phase;
  } lcdsd_timing_t;

  // ==========================================================
  // Default map: segment s, common c from word s, bit c
  function automatic lcdsd_map_all_t lcdsd_default_map();
    lcdsd_map_all_t m;
    m = '0;
    for (int s = 0; s < NSEG; s++) begin
      for (int c = 0; c < NCOM; c++) begin
        m[s][c].word = 6'(s);
        m[s][c].bitn = 2'(c);
      end
    end
    return m;
  endfunction : lcdsd_default_map

endpackage : lcdsd_pkg

//--- src/lcdsd_frame_gen.sv
// Frame and common-slot sequencer of the LCD segment driver.
// Assumes osc_tick is a one-cycle pulse per low oscillator period.
`timescale 1ns/100ps

module lcdsd_frame_gen
  import lcdsd_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // Control
  input  wire logic          osc_tick,
  input  wire logic          duty_third,
  input  wire logic          static_mode,
  // Timing out
  output lcdsd_timing_t      timing
);

  // ==========================================================
  // Frame counter
  localparam logic [CNT_W-1:0] LAST_Q =
    CNT_W'(FRAME_DIV_QUARTER - 1);
  localparam logic [CNT_W-1:0] LAST_T =
    CNT_W'(FRAME_DIV_THIRD - 1);
  localparam logic [CNT_W-1:0] HALF_Q =
    CNT_W'(FRAME_DIV_QUARTER / 2 - 1);
  localparam logic [CNT_W-1:0] HALF_T =
    CNT_W'(FRAME_DIV_THIRD / 2 - 1);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             phase_q, phase_d;
  logic [CNT_W-1:0] last_v, half_v;

  always_comb begin
    last_v  = duty_third ? LAST_T : LAST_Q; // (R3)
    half_v  = duty_third ? HALF_T : HALF_Q;
    cnt_d   = cnt_q;
    phase_d = phase_q;
    if (osc_tick) begin
      if (cnt_q >= last_v) begin
        cnt_d   = '0;
        phase_d = ~phase_q; // (R17)
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
        if (static_mode && cnt_q == half_v) begin
          phase_d = ~phase_q; // (R5)
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

  // Slot changes every SLOT_TICKS oscillator periods
  assign timing.slot  = cnt_q[CNT_W-1:SLOT_LSB]; // (R2)
  assign timing.phase = phase_q;

endmodule : lcdsd_frame_gen

//--- tb/lcdsd_top_sva.sv
// Checker of the LCD segment driver, watching the top module's ports.
// Assumes binding into lcdsd_top with its OPEN_DRAIN and DUTY_THIRD
// parameters.
`timescale 1ns/100ps

module lcdsd_top_sva
  import lcdsd_pkg::*;
#(
  parameter logic [NSEG-1:0] OPEN_DRAIN = '0,
  parameter logic            DUTY_THIRD = 1'b0
) (
  // Clock and reset
  input wire logic            clk_sys,
  input wire logic            rst_b,
  // Register port
  input wire lcdsd_bus_t      bus,
  input wire logic [3:0]      rd_data,
  // Mask bits
  input wire logic            tick32_int_mask,
  input wire logic            tick8_int_mask,
  input wire logic            tick2_int_mask,
  // Panel drive
  input wire logic [NCOM-1:0] common_outputs,
  input wire logic            common_phase,
  input wire logic [NSEG-1:0] segment_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Sequences
  sequence s_drv_wr;
    bus.wr && bus.addr == REG_DRIVE;
  endsequence
  sequence s_drv_rd;
    bus.rd && bus.addr == REG_DRIVE;
  endsequence
  wire logic [2:0] masks = {tick2_int_mask, tick8_int_mask, tick32_int_mask};
  // ==========================================================
  // Assertions
  a_mask_write: assert property (
    s_drv_wr |=> masks == $past(bus.wdata[2:0]))
    else $error("mask bits not written");
  a_drive_read: assert property (
    s_drv_rd |=> rd_data[2:0] == $past(masks))
    else $error("drive register read wrong");
  a_rd_idle: assert property (!$past(bus.rd) |-> rd_data == 4'h0)
    else $error("read data outside read cycle");
  a_unmapped_rd: assert property (
    bus.rd && bus.addr == 12'h2E9 |=> rd_data == 4'h0)
    else $error("unmapped read not zero");
  a_com_shape: assert property (
    $onehot0(common_outputs) || common_outputs == 4'hF)
    else $error("common outputs shape wrong");
  a_com_phase: assert property (
    common_outputs != 4'h0 |-> (common_outputs == 4'hF) == common_phase)
    else $error("common level against phase wrong");
  a_slot_order: assert property (
    $fell(common_outputs[0]) && common_outputs != 4'h0
    |-> common_outputs == 4'h2)
    else $error("common slot order wrong");
  a_phase_hold: assert property (
    $changed(common_phase) |=> $stable(common_phase) [*7])
    else $error("phase changed too soon");
  a_oe_push: assert property (
    $past(rst_b) |-> (segment_oe | OPEN_DRAIN) == '1)
    else $error("push-pull segment not driven");
  a_third_com3: assert property (
    DUTY_THIRD |-> common_outputs != 4'h8)
    else $error("fourth common active under third duty");
endmodule : lcdsd_top_sva

bind lcdsd_top lcdsd_top_sva #(.OPEN_DRAIN(OPEN_DRAIN),
  .DUTY_THIRD(DUTY_THIRD)) u_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
  .tick32_int_mask(tick32_int_mask), .tick8_int_mask(tick8_int_mask),
  .tick2_int_mask(tick2_int_mask), .common_outputs(common_outputs),
  .common_phase(common_phase), .segment_oe(segment_oe));

//--- tb/lcdsd_panel.sv
// Passive panel glass model: which segments see a lit voltage.
// Assumes digital drive levels; bias voltages are not modelled.
`timescale 1ns/100ps

module lcdsd_panel
  import lcdsd_pkg::*;
(
  // Drive from the block
  input  wire logic            common_phase,
  input  wire logic [NSEG-1:0] segment_outputs,
  // Seen by the bench
  output logic [NSEG-1:0]      lit
);
  // Segment against the frame polarity
  assign lit = segment_outputs ^ {NSEG{common_phase}};
endmodule : lcdsd_panel

//--- tb/tb_lcd_segment_driver.sv
// Bench of the LCD segment driver with a passive panel model.
// Assumes one block in page 0, 1/4 duty, DC pair 0, segment 1 open drain,
// and a second in page 2, 1/3 duty, sharing the bus and oscillator.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb_lcd_segment_driver
  import lcdsd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        low_osc_in = 1'b0;
  lcdsd_bus_t  bus = '0;
  logic [3:0]  rd_data, v;
  logic        t32, t8, t2, common_phase;
  logic [3:0]  rd2, v2, com2;
  logic        ph2;
  logic [47:0] seg2;
  logic [3:0]  common_outputs;
  logic [47:0] segment_outputs, segment_oe, lit, e;
  logic [3:0]  sh [48];
  logic [1:0]  osc_div = 2'h0;
  int          err_total = 0, comparisons = 0, cyc = 0, n;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3) low_osc_in <= ~low_osc_in;
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      wrap_up();
    end
  end

  lcdsd_top #(.DC_PAIRS(24'h000001), .OPEN_DRAIN(48'h0000_0000_0002)) dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
    .low_osc_in(low_osc_in), .tick32_int_mask(t32), .tick8_int_mask(t8),
    .tick2_int_mask(t2), .common_outputs(common_outputs),
    .common_phase(common_phase), .segment_outputs(segment_outputs),
    .segment_oe(segment_oe));
  lcdsd_panel u_panel (.common_phase(common_phase),
    .segment_outputs(segment_outputs), .lit(lit));
  lcdsd_top #(.PAGE2(1'b1), .DUTY_THIRD(1'b1)) dut_p2_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rd_data(rd2),
    .low_osc_in(low_osc_in), .tick32_int_mask(), .tick8_int_mask(),
    .tick2_int_mask(), .common_outputs(com2), .common_phase(ph2),
    .segment_outputs(seg2), .segment_oe());

  // ==========================================================
  // Bus and wait tasks
  task wr(input logic [11:0] a, input logic [3:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus <= '0;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus <= '0;
    #1 v = rd_data;
    v2 = rd2;
  endtask : rd
  task wait_ph(input logic p);
    n = 0;
    while (common_phase !== p && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask : wait_ph
  task wait_ph2(input logic p);
    n = 0;
    while (ph2 !== p && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask : wait_ph2

  // ==========================================================
  // Scenarios
  task t_regs;
    rd(REG_DRIVE); `CHK("drive reset", DRIVE_RST, v)
    wr(REG_DRIVE, 4'h7);
    rd(REG_DRIVE); `CHK("drive rw", 4'h7, v)
    `CHK("masks", 3'h7, {t2, t8, t32})
    rd(12'h2E9); `CHK("unmapped", 4'h0, v)
    wr(REG_DRIVE, 4'h0);
    $display("test regs done");
  endtask : t_regs
  task t_mem;
    for (int s = 0; s < 48; s++) begin
      sh[s] = 4'(s) ^ 4'h5;
      wr(MEM_BASE_P0 + 12'(s), sh[s]);
    end
    rd(MEM_BASE_P0); `CHK("word 0", sh[0], v)
    rd(12'h06F); `CHK("word 47", sh[47], v)
    rd(12'h070); `CHK("past end", 4'h0, v)
    $display("test mem done");
  endtask : t_mem
  task t_scan;
    for (int c = 0; c < 4; c++) begin
      n = 0;
      while (common_outputs !== 4'(1 << c) && n < 20000) begin
        @(posedge clk_sys);
        #1 n++;
      end
      for (int s = 0; s < 48; s++) e[s] = sh[s][c];
      `CHK("lit slot", e[47:2], lit[47:2])
      `CHK("dc seg0", sh[0][0], segment_outputs[0])
      `CHK("dc seg1", sh[1][0], segment_outputs[1])
      `CHK("od oe1", sh[1][0], segment_oe[1])
    end
    wait_ph(1'b0);
    wait_ph(1'b1);
    wait_ph(1'b0); `CHK("frame clks", 8192, n)
    $display("test scan done");
  endtask : t_scan
  task t_third;
    for (int s = 0; s < 48; s++) wr(MEM_BASE_P2 + 12'(s), sh[s]);
    rd(MEM_BASE_P2); `CHK("page2 read", RD_UNDEF, v2)
    for (int c = 0; c < 3; c++) begin
      n = 0;
      while (com2 !== 4'(1 << c) && n < 20000) begin
        @(posedge clk_sys);
        #1 n++;
      end
      for (int s = 0; s < 48; s++) e[s] = sh[s][c];
      `CHK("third slot", e, seg2)
    end
    wait_ph2(1'b1);
    wait_ph2(1'b0); `CHK("third frame", 6144, n)
    $display("test third done");
  endtask : t_third
  task t_static;
    for (int s = 0; s < 48; s++) wr(MEM_BASE_P0 + 12'(s), 4'hF);
    wr(REG_DRIVE, 4'h8);
    rd(REG_DRIVE); `CHK("static bit", 4'h8, v)
    wait_ph(1'b0);
    wait_ph(1'b1);
    `CHK("static com", {4{common_phase}}, common_outputs)
    `CHK("static lit", 46'h3FFF_FFFF_FFFF, lit[47:2])
    `CHK("od oe1 on", 1'b1, segment_oe[1])
    wait_ph(1'b0); `CHK("static half", 4096, n)
    wait_ph2(1'b0);
    wait_ph2(1'b1); `CHK("third static com", 4'hF, com2)
    wait_ph2(1'b0); `CHK("third static half", 3072, n)
    $display("test static done");
  endtask : t_static

  task wrap_up;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_mem();
    t_scan();
    t_third();
    t_static();
    wrap_up();
  end
endmodule : tb_lcd_segment_driver
